// File: core/aip_pkg.sv
// Package with register map, field layout and carrier types of the interrupt pin logic
package aip_pkg;
  localparam logic [7:0] ADDR_SOURCE_ENABLE = 8'h2E;
  localparam logic [7:0] ADDR_PIN_ROUTING = 8'h2F;
  localparam logic [7:0] ADDR_PENDING_SOURCES = 8'h30;
  localparam logic [7:0] ADDR_FORMAT_CONTROL = 8'h31;
  localparam logic [7:0] ADDR_DATA_FIRST = 8'h32;
  localparam logic [7:0] ADDR_DATA_LAST = 8'h37;
  localparam logic [7:0] RESET_SOURCE_ENABLE = 8'h00;
  localparam logic [7:0] RESET_PIN_ROUTING = 8'h00;
  localparam logic [7:0] RESET_FORMAT_CONTROL = 8'h00;
  localparam int BIT_NEW_SAMPLE = 7;
  localparam int BIT_WATERMARK = 1;
  localparam int BIT_OVERRUN = 0;
  localparam int BIT_POLARITY_INVERT = 5;
  // Data-related flags: held by their condition, not latched by a source read
  localparam logic [7:0] DATA_FLAG_MASK = 8'h83;
  localparam int NUM_SOURCES = 8;

  typedef struct packed {
    logic read_strobe;
    logic write_strobe;
    logic [7:0] address;
    logic [7:0] write_data;
  } aip_reg_req_type;

  typedef struct packed {
    logic [7:0] source_enable;
    logic [7:0] pin_routing;
    logic [7:0] format_control;
  } aip_config_type;
endpackage

// File: core/aip_flag_latch.sv
// Per-source latch of interrupt event flags
`timescale 1ns/10ps
module aip_flag_latch
  import aip_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Event and clear controls
  input wire logic [NUM_SOURCES-1:0] event_set,
  input wire logic [NUM_SOURCES-1:0] data_condition,
  input wire logic source_read,
  // Latched flags
  output logic [NUM_SOURCES-1:0] flags
);
  logic [NUM_SOURCES-1:0] next_flags;

  genvar i;
  generate
    for (i = 0; i < NUM_SOURCES; i++) begin : g_src
      always_comb begin
        if (DATA_FLAG_MASK[i]) begin
          // Tracks its condition; cleared only once data reads remove it
          next_flags[i] = data_condition[i] | event_set[i];
        end else if (event_set[i]) begin
          // Set wins over a simultaneous source read
          next_flags[i] = 1'b1;
        end else if (source_read) begin
          next_flags[i] = 1'b0;
        end else begin
          next_flags[i] = flags[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end
endmodule

// File: core/aip_irq_logic.sv
// Interrupt latch, enable, routing and polarity logic with register port
`timescale 1ns/10ps
module aip_irq_logic
  import aip_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Register port from the serial interface
  input wire aip_reg_req_type reg_req,
  output logic [7:0] read_data,
  output logic read_valid,
  // Events from sensing functions, one pulse per event
  input wire logic [NUM_SOURCES-1:0] event_set,
  // Live conditions of the data-related sources
  input wire logic [NUM_SOURCES-1:0] data_condition,
  // Interrupt pins, push-pull
  output logic irq_pin_first,
  output logic irq_pin_second,
  // Configuration seen by the rest of the device
  output aip_config_type config_out
);
  // Configuration bytes, one register group each
  logic [7:0] source_enable;
  logic [7:0] next_source_enable;
  logic [7:0] pin_routing;
  logic [7:0] next_pin_routing;
  logic [7:0] format_control;
  logic [7:0] next_format_control;
  aip_config_type next_config_out;
  // Address decode of the register port
  logic hit_source_enable;
  logic hit_pin_routing;
  logic hit_pending_sources;
  logic hit_format_control;
  logic write_source_enable;
  logic write_pin_routing;
  logic write_format_control;
  logic source_read;
  // Latched flags and their way to the pins
  logic [NUM_SOURCES-1:0] flags;
  wire logic [NUM_SOURCES-1:0] live;
  wire logic [NUM_SOURCES-1:0] route_first;
  wire logic [NUM_SOURCES-1:0] route_second;
  logic active_low;
  // Next values of the registered outputs
  logic next_read_valid;
  logic [7:0] next_read_data;
  logic next_pin_first;
  logic next_pin_second;

  // Address decode shared by the write and clear paths
  always_comb begin
    hit_source_enable = (reg_req.address == ADDR_SOURCE_ENABLE);
    hit_pin_routing = (reg_req.address == ADDR_PIN_ROUTING);
    hit_pending_sources = (reg_req.address == ADDR_PENDING_SOURCES);
    hit_format_control = (reg_req.address == ADDR_FORMAT_CONTROL);
  end

  // Write to pending sources or an unmapped address is dropped
  // Both strobes in one cycle both act
  always_comb begin
    write_source_enable = reg_req.write_strobe && hit_source_enable;
    write_pin_routing = reg_req.write_strobe && hit_pin_routing;
    write_format_control = reg_req.write_strobe && hit_format_control;
  end

  // Read of pending sources doubles as the clear of non-data flags
  always_comb begin
    source_read = reg_req.read_strobe && hit_pending_sources;
  end

  // Data flags follow their live condition; the rest stay latched
  aip_flag_latch u_aip_flag_latch (
    .clock(clock),
    .rst_b(rst_b),
    .event_set(event_set),
    .data_condition(data_condition),
    .source_read(source_read),
    .flags(flags)
  );

  // Enable gates each function on its way to the pins
  always_comb begin
    next_source_enable = source_enable;
    if (write_source_enable) begin
      next_source_enable = reg_req.write_data;
    end
  end

  // Register reset leaves every function disabled
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      source_enable <= RESET_SOURCE_ENABLE;
    end else begin
      source_enable <= next_source_enable;
    end
  end

  // One routing bit per function
  always_comb begin
    next_pin_routing = pin_routing;
    if (write_pin_routing) begin
      next_pin_routing = reg_req.write_data;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pin_routing <= RESET_PIN_ROUTING;
    end else begin
      pin_routing <= next_pin_routing;
    end
  end

  // All bits kept for the rest of the device; only the invert bit is used here
  always_comb begin
    next_format_control = format_control;
    if (write_format_control) begin
      next_format_control = reg_req.write_data;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      format_control <= RESET_FORMAT_CONTROL;
    end else begin
      format_control <= next_format_control;
    end
  end

  // Mirror for the rest of the device, updated at the same edge
  always_comb begin
    next_config_out.source_enable = next_source_enable;
    next_config_out.pin_routing = next_pin_routing;
    next_config_out.format_control = next_format_control;
  end

  // Reset mirrors the register reset values
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      config_out.source_enable <= RESET_SOURCE_ENABLE;
      config_out.pin_routing <= RESET_PIN_ROUTING;
      config_out.format_control <= RESET_FORMAT_CONTROL;
    end else begin
      config_out <= next_config_out;
    end
  end

  // Answer strobe for every read, mapped or not
  always_comb begin
    next_read_valid = reg_req.read_strobe;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      read_valid <= 1'b0;
    end else begin
      read_valid <= next_read_valid;
    end
  end

  // Pending view shows every flag whatever the enables, for polling hosts
  always_comb begin
    next_read_data = 8'h00;
    if (reg_req.read_strobe) begin
      case (reg_req.address)
        ADDR_SOURCE_ENABLE: next_read_data = source_enable;
        ADDR_PIN_ROUTING: next_read_data = pin_routing;
        // Captured before the same edge clears the non-data flags
        ADDR_PENDING_SOURCES: next_read_data = flags;
        ADDR_FORMAT_CONTROL: next_read_data = format_control;
        // Unmapped and sample data addresses read as zero here
        default: next_read_data = 8'h00;
      endcase
    end
  end

  // Read data stands for one cycle beside read valid
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      read_data <= 8'h00;
    end else begin
      read_data <= next_read_data;
    end
  end

  // Routing bit low selects the first pin, high the second
  // A flag masked here still shows in the pending view
  genvar src;
  generate
    for (src = 0; src < NUM_SOURCES; src++) begin : g_route
      assign live[src] = flags[src] & source_enable[src];
      assign route_first[src] = live[src] & ~pin_routing[src];
      assign route_second[src] = live[src] & pin_routing[src];
    end
  endgenerate

  // One invert bit serves both pins
  always_comb begin
    active_low = format_control[BIT_POLARITY_INVERT];
  end

  // Pins are always driven; only the asserted level flips
  always_comb begin
    next_pin_first = |route_first;
    next_pin_second = |route_second;
    // Inverting after the OR keeps one shared level per pin
    if (active_low) begin
      next_pin_first = ~next_pin_first;
      next_pin_second = ~next_pin_second;
    end
  end

  // Both pins low from reset, which is the active-high idle level
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      irq_pin_first <= 1'b0;
      irq_pin_second <= 1'b0;
    end else begin
      irq_pin_first <= next_pin_first;
      irq_pin_second <= next_pin_second;
    end
  end
endmodule

// File: verif/aip_irq_asserts.sv
// Port assertions of the interrupt pin logic
`timescale 1ns/10ps
module aip_irq_asserts
  import aip_pkg::*;
(
  // Observed ports
  input wire logic clock,
  input wire logic rst_b,
  input wire aip_reg_req_type reg_req,
  input wire logic [7:0] read_data,
  input wire logic [NUM_SOURCES-1:0] event_set,
  input wire logic [NUM_SOURCES-1:0] data_condition,
  input wire logic irq_pin_first,
  input wire logic irq_pin_second,
  input wire aip_config_type config_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  wire logic rs = reg_req.read_strobe && reg_req.address == ADDR_PENDING_SOURCES;
  wire logic inv = config_out.format_control[BIT_POLARITY_INVERT];
  wire logic [7:0] en = event_set & config_out.source_enable;
  a_fmt_write: assert property (reg_req.write_strobe && reg_req.address == 8'h31
    |=> config_out.format_control == $past(reg_req.write_data)) else $error("fmt");
  a_pending_ro: assert property (reg_req.write_strobe && reg_req.address == 8'h30
    |=> $stable(config_out)) else $error("ro");
  a_idle_level: assert property (config_out.source_enable == 8'h00
    |=> irq_pin_first == $past(inv) && irq_pin_second == $past(inv)) else $error("idle");
  a_route_first: assert property ((en & ~config_out.pin_routing) != 0
    |-> ##2 irq_pin_first != inv) else $error("first");
  a_route_second: assert property ((en & config_out.pin_routing) != 0
    |-> ##2 irq_pin_second != inv) else $error("second");
  a_new_sample: assert property ($past(data_condition[BIT_NEW_SAMPLE]) && rs
    |=> read_data[BIT_NEW_SAMPLE]) else $error("sample");
  a_overrun_hold: assert property ($past(data_condition[BIT_OVERRUN]) && rs
    |=> read_data[BIT_OVERRUN]) else $error("overrun");
  a_read_clear: assert property (rs && event_set == 0 && (data_condition & 8'h83) == 0
    |=> ##1 irq_pin_first == inv && irq_pin_second == inv) else $error("clear");
endmodule

// File: verif/aip_host_model.sv
// Host model issuing register requests
`timescale 1ns/10ps
module aip_host_model
  import aip_pkg::*;
(
  // Clock and answer
  input wire logic clock,
  input wire logic [7:0] read_data,
  input wire logic read_valid,
  // Requests
  output aip_reg_req_type reg_req
);
  initial reg_req = '0;
  // Idle fields inverted so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock) reg_req = {2'b01, a, d};
    @(negedge clock) reg_req = {2'b00, ~a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock) reg_req = {2'b10, a, 8'h00};
    @(negedge clock) d = read_valid ? read_data : 8'hxx;
    reg_req = {2'b00, ~a, 8'hff};
  endtask
endmodule

// File: verif/aip_irq_logic_tb_top.sv
// Testbench of the interrupt pin logic
`timescale 1ns/10ps
module aip_irq_logic_tb_top;
  import aip_pkg::*;
  logic clock = 0;
  logic rst_b = 0;
  logic [7:0] event_set = 0;
  logic [7:0] data_condition = 0;
  logic [7:0] read_data, v;
  logic read_valid, irq_pin_first, irq_pin_second;
  aip_reg_req_type reg_req;
  aip_config_type config_out;
  int n_fail = 0;
  int n_checks = 0;
  initial forever #2 clock = ~clock;
  aip_irq_logic u_aip_irq_logic (.clock(clock), .rst_b(rst_b), .reg_req(reg_req),
    .read_data(read_data), .read_valid(read_valid), .event_set(event_set),
    .data_condition(data_condition), .irq_pin_first(irq_pin_first),
    .irq_pin_second(irq_pin_second), .config_out(config_out));
  aip_host_model u_aip_host_model (.clock(clock), .read_data(read_data),
    .read_valid(read_valid), .reg_req(reg_req));
  task automatic check(input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    u_aip_host_model.rd(a, v);
    check(v, e);
  endtask
  task automatic pins(input int n, input logic [7:0] e);
    repeat (n) @(negedge clock);
    check({6'h00, irq_pin_second, irq_pin_first}, e);
  endtask
  task automatic finish_test();
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Whole run is about 55 cycles; the time limit lies at 2000 cycles
  initial begin
    #8000;
    n_fail++;
    finish_test();
  end
  initial begin
    repeat (10) @(negedge clock);
    rst_b = 1;
    rc(8'h2e, 8'h00);
    rc(8'h31, 8'h00);
    pins(0, 8'h00);
    $display("test reset done");
    u_aip_host_model.wr(8'h2f, 8'h10);
    u_aip_host_model.wr(8'h2e, 8'h11);
    @(negedge clock) event_set = 8'h11;
    data_condition = 8'h01;
    @(negedge clock) event_set = 8'h00;
    pins(1, 8'h03);
    rc(8'h30, 8'h11);
    pins(1, 8'h01);
    data_condition = 8'h00;
    pins(2, 8'h00);
    $display("test routing done");
    u_aip_host_model.wr(8'h31, 8'h20);
    pins(2, 8'h03);
    u_aip_host_model.wr(8'h2e, 8'h00);
    u_aip_host_model.wr(8'h2f, 8'h80);
    u_aip_host_model.wr(8'h2e, 8'h80);
    u_aip_host_model.wr(8'h30, 8'hff);
    data_condition = 8'h80;
    pins(2, 8'h01);
    rc(8'h30, 8'h80);
    data_condition = 8'h00;
    pins(2, 8'h03);
    @(negedge clock) event_set = 8'h04;
    @(negedge clock) event_set = 8'h00;
    pins(1, 8'h03);
    rc(8'h30, 8'h04);
    rc(8'h2e, 8'h80);
    rc(8'h2f, 8'h80);
    $display("test polarity done");
    finish_test();
  end
endmodule
bind aip_irq_logic aip_irq_asserts u_aip_irq_asserts (.clock(clock), .rst_b(rst_b),
  .reg_req(reg_req), .read_data(read_data), .event_set(event_set),
  .data_condition(data_condition), .irq_pin_first(irq_pin_first),
  .irq_pin_second(irq_pin_second), .config_out(config_out));
